// >>> rtl/abu_regs.svh
// Register offsets, field positions, reset values and vectors of the
// address breakpoint unit.
// Assumes inclusion by bare name from the package and the design.
`ifndef ABU_REGS_SVH
`define ABU_REGS_SVH
// ==========================================================
// Register byte addresses
`define ABU_ADDR_HIGH_OFS 16'hfe0c
`define ABU_ADDR_LOW_OFS 16'hfe0d
`define ABU_STATUS_CTRL_OFS 16'hfe0e
`define ABU_FLAG_CTRL_OFS 16'hfe10
`define ABU_SYS_STATUS_OFS 16'hfe14
`define ABU_IRQ_STATUS_OFS 16'hfe18
`define ABU_IRQ_MASK_OFS 16'hfe1c
// ==========================================================
// Field positions
`define ABU_ENABLE_BIT 7
`define ABU_ACTIVE_BIT 6
`define ABU_FLAG_CLR_BIT 7
`define ABU_STOPWAIT_BIT 1
`define ABU_EV_MATCH_BIT 0
`define ABU_EV_SOFT_BIT 1
`define ABU_EV_END_BIT 2
// ==========================================================
// Reset values and vectors
`define ABU_BYTE_RESET 8'h00
`define ABU_VEC_NORMAL 16'hfffc
`define ABU_VEC_MONITOR 16'hfefc
`endif

// >>> rtl/abu_pkg.sv
// Types shared by the address breakpoint unit and its bench.
// Assumes abu_regs.svh sits beside it on the include path.
`include "abu_regs.svh"
package abu_pkg;
   // CPU side request and observation bundle
   typedef struct packed {
      logic [15:0] addr;
      logic        pc_fetch;
      logic        last_cycle;
      logic        int_return;
      logic        wait_mode;
      logic        stop_mode;
      logic        monitor_mode;
   } abu_cpu_t;
   // Break sequencing states
   typedef enum logic [1:0] {
      ABU_IDLE,
      ABU_PEND,
      ABU_ACTIVE
   } abu_state_t;
   // Module state other than rd_done
   typedef struct packed {
      abu_state_t  state;
      logic [7:0]  addr_high;
      logic [7:0]  addr_low;
      logic        enable;
      logic        active_flag;
      logic        flag_clr_en;
      logic        stopwait;
      logic [2:0]  irq_status;
      logic [2:0]  irq_mask;
      logic [31:0] prdata;
      logic [15:0] vector;
      logic        vhi_s1;
      logic        vhi_s2;
   } abu_state_s_t;
endpackage

// >>> rtl/abu_break_unit.sv
// Address breakpoint unit: comparator, break sequencing, APB registers.
// Assumes CPU control inputs are on clock_i; only the test voltage
// detector arrives from a pin and is synchronised here.
`include "abu_regs.svh"
// Notes on behaviour
// RL1: Address match requests a break; CPU substitutes a software interrupt.
// RL2: Only program counter fetch addresses are compared for match breaks.
// RL3: Break vector is FFFC normally, FEFC in monitor mode.
// RL4: Match on an instruction's last cycle starts the break at once.
// RL5: Return from interrupt inside the handler ends the break state.
// RL6: Writing one to the active flag triggers a break without a match.
// RL7: Enable bit 7 is read/write, gates 16-bit match breaks, reset clears.
// RL8: Active flag set by hardware on match, reads one, reset clears.
// RL9: Handler software clears the active flag by writing zero before exit.
// RL10: High and low address registers at FE0C and FE0D, reset to zero.
// RL11: Flag-clear enable bit lets peripherals clear status during a break.
// RL12: Timer counter is frozen while a break is in progress.
// RL13: Watchdog held off during break when high test voltage is seen.
// RL14: Unit works in wait mode; break exit from wait sets stop/wait flag.
// RL15: Stop mode keeps registers and suppresses address comparison.
// RL16: A break leaves stop mode and sets the stop/wait flag.
// RL17: Compare value is high register on 15..8, low register on 7..0.
module abu_break_unit
   import abu_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [15:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire abu_cpu_t cpu_i,
   input wire logic high_test_voltage_i,
   output logic break_req_o,
   output logic break_now_o,
   output logic [15:0] break_vector_o,
   output logic break_active_o,
   output logic timer_freeze_o,
   output logic watchdog_hold_o,
   output logic flag_clear_allow_o,
   output logic stop_exit_o,
   output logic irq_o
);
   // ==========================================================
   // Address decode
   function automatic logic hit(input logic [15:0] a,
                                input logic [15:0] ofs);
      hit = (a[15:2] == ofs[15:2]);
   endfunction

   abu_state_s_t r;
   abu_state_s_t next_r;
   logic wr;
   logic rd;
   logic mapped;
   logic lane0;
   logic [15:0] bp_addr;
   logic match;
   logic soft_trig;
   logic start;
   logic [7:0] wb;

   // Byte address offsets fe0c..fe0e share one word, lane picks byte
   assign wr = psel_i & penable_i & pwrite_i;
   assign rd = psel_i & penable_i & ~pwrite_i;
   assign mapped = hit(paddr_i, `ABU_ADDR_HIGH_OFS) |
                   hit(paddr_i, `ABU_FLAG_CTRL_OFS) |
                   hit(paddr_i, `ABU_SYS_STATUS_OFS) |
                   hit(paddr_i, `ABU_IRQ_STATUS_OFS) |
                   hit(paddr_i, `ABU_IRQ_MASK_OFS);
   assign lane0 = pstrb_i[0];
   assign wb = pwdata_i[7:0];

   // ==========================================================
   // Comparator
   assign bp_addr = {r.addr_high, r.addr_low}; // [RL17]
   // Fetch addresses only, and none while stopped [RL2] [RL15]
   assign match = r.enable & cpu_i.pc_fetch & ~cpu_i.stop_mode &
                  (cpu_i.addr == bp_addr); // [RL7]
   // Soft trigger: write of one into the active flag
   assign soft_trig = wr & hit(paddr_i, `ABU_ADDR_HIGH_OFS) &
                      pstrb_i[2] & pwdata_i[16+`ABU_ACTIVE_BIT]; // [RL6]
   assign start = (r.state == ABU_IDLE) & (match | soft_trig);

   // ==========================================================
   // Next state
   always_comb begin
      next_r = r;
      next_r.vhi_s1 = high_test_voltage_i;
      next_r.vhi_s2 = r.vhi_s1;
      next_r.prdata = 32'h0000_0000;
      next_r.vector = cpu_i.monitor_mode ? `ABU_VEC_MONITOR
                                         : `ABU_VEC_NORMAL; // [RL3]
      // Register writes
      if (wr && hit(paddr_i, `ABU_ADDR_HIGH_OFS)) begin
         if (lane0) begin
            next_r.addr_high = wb; // [RL10]
         end
         if (pstrb_i[1]) begin
            next_r.addr_low = pwdata_i[15:8]; // [RL10]
         end
         if (pstrb_i[2]) begin
            next_r.enable = pwdata_i[16+`ABU_ENABLE_BIT]; // [RL7]
            // Zero clears, software duty of the handler [RL9]
            next_r.active_flag = pwdata_i[16+`ABU_ACTIVE_BIT];
         end
      end
      if (wr && lane0 && hit(paddr_i, `ABU_FLAG_CTRL_OFS)) begin
         next_r.flag_clr_en = wb[`ABU_FLAG_CLR_BIT];
      end
      if (wr && lane0 && hit(paddr_i, `ABU_SYS_STATUS_OFS) &&
          !wb[`ABU_STOPWAIT_BIT]) begin
         next_r.stopwait = 1'b0;
      end
      if (wr && lane0 && hit(paddr_i, `ABU_IRQ_MASK_OFS)) begin
         next_r.irq_mask = wb[2:0];
      end
      // Write one to clear; events below set after, so set wins
      if (wr && lane0 && hit(paddr_i, `ABU_IRQ_STATUS_OFS)) begin
         next_r.irq_status = r.irq_status & ~wb[2:0];
      end
      // Break sequencing
      case (r.state)
         ABU_IDLE: begin
            if (start) begin
               next_r.active_flag = 1'b1; // [RL8]
               // Last-cycle match skips waiting [RL4]
               next_r.state = cpu_i.last_cycle ? ABU_ACTIVE : ABU_PEND;
               if (cpu_i.wait_mode || cpu_i.stop_mode) begin
                  next_r.stopwait = 1'b1; // [RL14] [RL16]
               end
               next_r.irq_status[`ABU_EV_MATCH_BIT] = match |
                  r.irq_status[`ABU_EV_MATCH_BIT];
               next_r.irq_status[`ABU_EV_SOFT_BIT] = soft_trig |
                  r.irq_status[`ABU_EV_SOFT_BIT];
            end
         end
         ABU_PEND: begin
            // Held until the current instruction completes [RL1]
            if (cpu_i.last_cycle) begin
               next_r.state = ABU_ACTIVE;
            end
         end
         ABU_ACTIVE: begin
            if (cpu_i.int_return) begin
               next_r.state = ABU_IDLE; // [RL5]
               next_r.irq_status[`ABU_EV_END_BIT] = 1'b1;
            end
         end
         default: begin
            next_r.state = ABU_IDLE;
         end
      endcase
      // Read data, registered at the first access edge
      if (rd) begin
         if (hit(paddr_i, `ABU_ADDR_HIGH_OFS)) begin
            next_r.prdata = {8'h00, r.enable, r.active_flag, 6'h00,
                             r.addr_low, r.addr_high};
         end else if (hit(paddr_i, `ABU_FLAG_CTRL_OFS)) begin
            next_r.prdata = {24'h000000, r.flag_clr_en, 7'h00};
         end else if (hit(paddr_i, `ABU_SYS_STATUS_OFS)) begin
            next_r.prdata = {30'h00000000, r.stopwait, 1'b0};
         end else if (hit(paddr_i, `ABU_IRQ_STATUS_OFS)) begin
            next_r.prdata = {29'h00000000, r.irq_status};
         end else if (hit(paddr_i, `ABU_IRQ_MASK_OFS)) begin
            next_r.prdata = {29'h00000000, r.irq_mask};
         end else begin
            next_r.prdata = 32'h0000_0000;
         end
      end
   end

   // ==========================================================
   // State register; stop mode gates no field, registers keep values unless written
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r.state <= ABU_IDLE;
         r.addr_high <= `ABU_BYTE_RESET; // [RL10]
         r.addr_low <= `ABU_BYTE_RESET; // [RL10]
         r.enable <= 1'b0; // [RL7]
         r.active_flag <= 1'b0; // [RL8]
         r.flag_clr_en <= 1'b0;
         r.stopwait <= 1'b0;
         r.irq_status <= 3'h0;
         r.irq_mask <= 3'h0;
         r.prdata <= 32'h0000_0000;
         r.vector <= `ABU_VEC_NORMAL;
         r.vhi_s1 <= 1'b0;
         r.vhi_s2 <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   // ==========================================================
   // Outputs
   // Writes finish at once; read data is registered at the first
   // access edge, so pready holds off one cycle for reads
   logic rd_done;
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_done <= 1'b0;
      end else begin
         rd_done <= rd & ~rd_done;
      end
   end
   assign pready_o = pwrite_i ? 1'b1 : rd_done;
   assign pslverr_o = psel_i & penable_i & pready_o & ~mapped;
   assign prdata_o = r.prdata;
   assign break_req_o = (r.state != ABU_IDLE); // [RL1]
   assign break_now_o = (r.state == ABU_ACTIVE);
   assign break_vector_o = r.vector; // [RL3]
   assign break_active_o = (r.state == ABU_ACTIVE);
   assign timer_freeze_o = (r.state == ABU_ACTIVE); // [RL12]
   assign watchdog_hold_o = (r.state == ABU_ACTIVE) & r.vhi_s2; // [RL13]
   // Peripheral clears pass outside a break, or when enabled [RL11]
   assign flag_clear_allow_o = (r.state != ABU_ACTIVE) | r.flag_clr_en;
   assign stop_exit_o = (r.state != ABU_IDLE) & cpu_i.stop_mode; // [RL16]
   assign irq_o = |(r.irq_status & r.irq_mask);
endmodule

// >>> test/abu_break_unit_properties.sv
// Port checks of the breakpoint unit.
// Assumes one clock domain and the bind below.
// ===========================================
// Checker
module abu_break_unit_chk
   import abu_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire abu_cpu_t cpu_i,
   input wire logic high_test_voltage_i,
   input wire logic break_req_o,
   input wire logic break_active_o,
   input wire logic [15:0] break_vector_o,
   input wire logic timer_freeze_o,
   input wire logic watchdog_hold_o,
   input wire logic flag_clear_allow_o,
   input wire logic stop_exit_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // A request needs a fetch match or a register write behind it
   a_fetch_only: assert property (
      $rose(break_req_o) |-> $past(cpu_i.pc_fetch) || $past(psel_i))
      else $error("break without fetch or write");
   a_last_start: assert property (
      break_req_o && !break_active_o && cpu_i.last_cycle |=> break_active_o)
      else $error("pending break missed last cycle");
   // Trigger on an instruction boundary: the break starts at once
   a_last_now: assert property (
      !break_req_o && cpu_i.last_cycle ##1 break_req_o |-> break_active_o)
      else $error("boundary break did not start at once");
   a_rti_ends: assert property (
      break_active_o && cpu_i.int_return |=> !break_req_o)
      else $error("return did not end break");
   a_timer_freeze: assert property (
      timer_freeze_o == break_active_o)
      else $error("timer freeze wrong");
   // Vector lags the mode by one cycle, so the mode must hold two
   a_vector_mon: assert property (
      cpu_i.monitor_mode ##1 cpu_i.monitor_mode |->
      break_vector_o == 16'hfefc)
      else $error("monitor vector wrong");
   a_wdog_hold: assert property (
      high_test_voltage_i [*3] ##0 break_active_o |-> watchdog_hold_o)
      else $error("watchdog not held");
   a_flag_gate: assert property (
      !break_active_o |-> flag_clear_allow_o)
      else $error("flag clears blocked outside break");
   a_stop_exit: assert property (
      cpu_i.stop_mode && break_req_o |-> stop_exit_o)
      else $error("no stop exit on break");
   cover property ($rose(break_active_o));
   cover property (watchdog_hold_o);
   cover property (stop_exit_o);
endmodule

bind abu_break_unit abu_break_unit_chk u_chk (.clock_i, .rst_n_i,
   .psel_i, .cpu_i, .high_test_voltage_i, .break_req_o, .break_active_o,
   .break_vector_o, .timer_freeze_o, .watchdog_hold_o,
   .flag_clear_allow_o, .stop_exit_o);

// >>> test/abu_cpu_model.sv
// CPU core model: fetch stream, break entry, handler return.
// Assumes the unit's clock; the bench sets the handler length.
// ===========================================
// Model
module abu_cpu_model
   import abu_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic run_i,
   input wire logic [15:0] start_i,
   input wire logic [7:0] slow_i,
   input wire logic [2:0] modes_i,
   input wire logic break_now_i,
   output abu_cpu_t cpu_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic in_h;
   logic [7:0] cnt;
   // Two-cycle instructions; fetch halts inside the handler
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cpu_o <= '0;
         in_h <= 1'b0;
         cnt <= 8'h00;
      end else begin
         {cpu_o.wait_mode, cpu_o.stop_mode, cpu_o.monitor_mode} <= modes_i;
         cpu_o.int_return <= 1'b0;
         if (in_h) begin
            cpu_o.pc_fetch <= 1'b0;
            cpu_o.addr <= ~cpu_o.addr; // Bus not held outside fetches
            cnt <= cnt - 8'h01;
            if (cnt == 8'h00) begin
               cpu_o.int_return <= 1'b1;
               in_h <= 1'b0;
            end
         end else if (break_now_i && !cpu_o.int_return) begin
            in_h <= 1'b1; // Takes the substituted interrupt
            cnt <= slow_i;
            cpu_o.pc_fetch <= 1'b0;
         end else begin
            cpu_o.pc_fetch <= run_i;
            cpu_o.addr <= run_i ? cpu_o.addr + 16'h0001 : start_i;
            // Odd fetch addresses end an instruction; idle core is at one
            cpu_o.last_cycle <= ~run_i | ~cpu_o.addr[0];
         end
      end
   end
endmodule

// >>> test/abu_break_unit_tb_top.sv
// Bench for the breakpoint unit with a CPU model.
// Assumes abu_pkg compiled first; checker bound separately.
// ===========================================
// Bench
module abu_break_unit_tb_top
   import abu_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {
      logic [15:0] a;
      logic [31:0] w;
      logic [31:0] r;
      logic e;
   } abu_row_t;
   abu_row_t rows [4] = '{'{16'hfe0c, 32'h3412, 32'h3412, 1'b0},
      '{16'hfe10, 32'h80, 32'h80, 1'b0}, '{16'hfe1c, 32'h7, 32'h7, 1'b0},
      '{16'hfe20, 32'hff, 32'h0, 1'b1}};
   logic clock_i, rst_n_i, psel_i, penable_i, pwrite_i, hv, run, err;
   logic pready_o, pslverr_o, req, now, act, frz, wdh, fca, sxo, irq;
   logic [15:0] paddr_i, start, vec;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic [3:0] pstrb_i;
   logic [7:0] slow;
   logic [2:0] modes;
   abu_cpu_t cpu;
   int miscompares, n_tests;
   abu_break_unit uut (.clock_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i,
      .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o,
      .cpu_i(cpu), .high_test_voltage_i(hv), .break_req_o(req),
      .break_now_o(now), .break_vector_o(vec), .break_active_o(act),
      .timer_freeze_o(frz), .watchdog_hold_o(wdh),
      .flag_clear_allow_o(fca), .stop_exit_o(sxo), .irq_o(irq));
   abu_cpu_model cpu_m (.clock_i, .rst_n_i, .run_i(run), .start_i(start),
      .slow_i(slow), .modes_i(modes), .break_now_i(now), .cpu_o(cpu));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // One APB transfer; an idle cycle after keeps strobes single-driven
   task automatic apb(input logic wr, input logic [15:0] a,
         input logic [31:0] wd);
      int n;
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, wr, a, wd};
      @(posedge clock_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (pready_o !== 1'b1 && n < 50);
      rd = prdata_o;
      err = pslverr_o;
      {psel_i, penable_i} <= 2'b00;
      if (pready_o !== 1'b1) begin
         miscompares++;
         close_out();
      end
      @(posedge clock_i);
   endtask
   // Bounded wait on the active break state or the request
   task automatic wait_on(input logic sel, input logic lvl);
      int n;
      n = 0;
      while ((sel ? act : req) !== lvl && n < 200) begin
         @(posedge clock_i);
         n++;
      end
      if ((sel ? act : req) !== lvl) begin
         miscompares++;
         close_out();
      end
   endtask
   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end
   initial begin
      {rst_n_i, psel_i, penable_i, pwrite_i, hv, run} = '0;
      {paddr_i, pwdata_i, start, modes} = '0;
      pstrb_i = 4'hf;
      slow = 8'd20;
      repeat (2) @(posedge clock_i);
      rst_n_i <= 1'b1;
      apb(1'b0, 16'hfe0c, 32'h0);
      chk(rd, 32'h0);
      chk(32'({irq, fca}), 32'h1);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, rows[i].a, rows[i].w);
         apb(1'b0, rows[i].a, 32'h0);
         chk(rd, rows[i].r);
         chk(32'(err), 32'(rows[i].e));
      end
      // Fetch over the target with enable clear, then a non-fetch match
      start <= 16'h1230; // Origin loads while the model idles
      apb(1'b1, 16'hfe10, 32'h0);
      run <= 1'b1;
      repeat (12) @(posedge clock_i);
      {start, run} <= {16'h1234, 1'b0};
      apb(1'b1, 16'hfe0c, 32'h0080_3412);
      repeat (4) @(posedge clock_i);
      apb(1'b0, 16'hfe0c, 32'h0);
      chk(rd, 32'h0080_3412);
      // Match break in wait mode
      {modes, start} <= {3'b100, 16'h1230};
      @(posedge clock_i);
      run <= 1'b1;
      wait_on(1'b1, 1'b1);
      run <= 1'b0;
      chk(32'({vec, frz, fca, irq}), 32'({16'hfffc, 3'b101}));
      apb(1'b0, 16'hfe0c, 32'h0);
      chk(rd, 32'h00c0_3412);
      wait_on(1'b0, 1'b0);
      apb(1'b0, 16'hfe14, 32'h0);
      chk(rd, 32'h2);
      apb(1'b1, 16'hfe0c, 32'h0080_3412);
      apb(1'b1, 16'hfe14, 32'h0);
      apb(1'b1, 16'hfe18, 32'h7);
      chk(32'(irq), 32'h0);
      // Stop mode: no comparison, registers kept
      {hv, modes, run} <= {1'b1, 3'b011, 1'b1};
      apb(1'b1, 16'hfe10, 32'h80);
      repeat (12) @(posedge clock_i);
      run <= 1'b0;
      apb(1'b0, 16'hfe0c, 32'h0);
      chk(rd, 32'h0080_3412);
      chk(32'(req), 32'h0);
      // Soft break wakes from stop, monitor vector, watchdog held
      slow <= 8'd40;
      apb(1'b1, 16'hfe0c, 32'h0040_3412);
      wait_on(1'b1, 1'b1);
      chk(32'({vec, wdh, sxo, fca}), 32'({16'hfefc, 3'b111}));
      wait_on(1'b0, 1'b0);
      apb(1'b0, 16'hfe14, 32'h0);
      chk(rd, 32'h2);
      // Reset mid-run with the active flag still set
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      rst_n_i <= 1'b1;
      apb(1'b0, 16'hfe0c, 32'h0);
      chk(rd, 32'h0);
      close_out();
   end
endmodule
